// File: amc_pkg.sv
// Register map, field positions and reset values of the analog switch control
package amc_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] SWITCH_CTRL_IDX  = 8'h03;
  localparam logic [7:0] ANALOG_CTRL_IDX  = 8'h1e;
  localparam logic [7:0] ANALOG_STAT_IDX  = 8'h1d;

  // Analog switch control register fields
  localparam int CHAN_SEL_LSB   = 0;
  localparam int CHAN_SEL_W     = 4;
  localparam int IDLE_LEVEL_BIT = 5;
  localparam int DIVIDED_BIT    = 6;
  localparam int DIRECT_BIT     = 7;

  // Analog control register fields
  localparam int CUR_EN_BIT     = 0;
  localparam int CHARGE_BIT     = 1;
  localparam int MODE1_BIT      = 2;
  localparam int MODE2_BIT      = 3;

  // Analog status register fields
  localparam int CAP_OFFSET_BIT = 0;
  localparam int CHARGE_NOW_BIT = 1;
  localparam int ANY_CHAN_BIT   = 2;

  // Reset values
  localparam logic [7:0] SWITCH_CTRL_RST = 8'h00;
  localparam logic [7:0] ANALOG_CTRL_RST = 8'h00;
  localparam logic [7:0] ANALOG_STAT_RST = 8'h00;

  // Writable bits of each register
  localparam logic [7:0] SWITCH_CTRL_MASK = 8'hef;
  localparam logic [7:0] ANALOG_CTRL_MASK = 8'h0f;
  localparam logic [7:0] ANALOG_STAT_MASK = 8'h01;

  // True when any channel select bit is set
  function automatic logic any_chan(input logic [CHAN_SEL_W-1:0] sel);
    any_chan = |sel;
  endfunction : any_chan

endpackage : amc_pkg

// File: amc_apb_slave.sv
// APB slave front end with one wait-free access phase and registered read data
`timescale 1ns/1ps
`default_nettype none

module amc_apb_slave (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Register side
  input  wire logic [7:0]  switchCtrl,
  input  wire logic [7:0]  analogCtrl,
  input  wire logic [7:0]  analogStat,
  output logic             wrStb,
  output logic      [7:0]  wrIdx,
  output logic      [7:0]  wrData
);

  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  idx;
  logic        hit;

  ////////////////////////////////////////////////////////////////////////////
  // Decode during setup, answer in the first access cycle
  always_comb begin
    idx          = {2'b00, paddr[7:2]};
    hit          = (paddr[1:0] == 2'b00) &&
                   (idx == amc_pkg::SWITCH_CTRL_IDX ||
                    idx == amc_pkg::ANALOG_CTRL_IDX ||
                    idx == amc_pkg::ANALOG_STAT_IDX);
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    next_prdata  = 32'h0000_0000;
    // Refused addresses read as zero, even when the index alone would match
    if (psel && !penable && !pwrite && hit) begin
      case (idx)
        amc_pkg::SWITCH_CTRL_IDX: next_prdata = {24'h00_0000, switchCtrl};
        amc_pkg::ANALOG_CTRL_IDX: next_prdata = {24'h00_0000, analogCtrl};
        amc_pkg::ANALOG_STAT_IDX: next_prdata = {24'h00_0000, analogStat};
        default:                  next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Answer registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // Write strobe at the completing edge; refused writes never strobe
  assign wrStb  = psel && penable && pready && pwrite && !pslverr;
  assign wrIdx  = {2'b00, paddr[7:2]};
  assign wrData = pwdata[7:0];

endmodule : amc_apb_slave

`default_nettype wire

// File: amc_switch_drive.sv
// Registered drivers of the analog switches and current steering
`timescale 1ns/1ps
`default_nettype none

module amc_switch_drive (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control values
  input  wire logic [7:0] switchCtrl,
  input  wire logic       curEnable,
  input  wire logic       chargeNow,
  input  wire logic       capOffset,
  // Switch drivers
  output logic      [3:0] chanSwitch,
  output logic            idleSupplyTie,
  output logic            idleGroundTie,
  output logic            directPath,
  output logic            dividedPath,
  output logic            tempDiodePath,
  output logic            dummyCompMux,
  output logic            capOffsetRef,
  output logic            currentSourceOn,
  output logic            currentToPin,
  output logic            currentToGround,
  output logic            dischargeOn
);

  logic [3:0] next_chanSwitch;
  logic       next_idleSupplyTie, next_idleGroundTie;
  logic       next_directPath, next_dividedPath, next_tempDiodePath;
  logic       next_dummyCompMux, next_capOffsetRef;
  logic       next_currentSourceOn, next_currentToPin;
  logic       next_currentToGround, next_dischargeOn;
  logic       anyChan, dir, div;

  ////////////////////////////////////////////////////////////////////////////
  // Switch decode
  always_comb begin
    anyChan = amc_pkg::any_chan(switchCtrl[amc_pkg::CHAN_SEL_LSB +: amc_pkg::CHAN_SEL_W]);
    dir     = switchCtrl[amc_pkg::DIRECT_BIT];
    div     = switchCtrl[amc_pkg::DIVIDED_BIT];
    // [R01] Independent channel switches
    // [R04] Applied without sequencing
    next_chanSwitch      = switchCtrl[amc_pkg::CHAN_SEL_LSB +: amc_pkg::CHAN_SEL_W];
    // [R02] Idle level tie
    // [R03] Opened by any channel
    next_idleSupplyTie   = !anyChan && switchCtrl[amc_pkg::IDLE_LEVEL_BIT];
    next_idleGroundTie   = !anyChan && !switchCtrl[amc_pkg::IDLE_LEVEL_BIT];
    // [R18] No source when clear
    // [R07] Direct path
    next_directPath      = dir && !div;
    // [R08] Divided path
    next_dividedPath     = div && !dir;
    // [R09] Temperature diode
    next_tempDiodePath   = dir && div;
    // [R11] Dummy compensation mux
    next_dummyCompMux    = div && !dir;
    // [R10] Capacitor reference end
    next_capOffsetRef    = capOffset;
    // [R12] Source kept running
    // [R16] Off with enable clear
    next_currentSourceOn = curEnable;
    next_currentToPin    = curEnable && chargeNow;
    next_currentToGround = curEnable && !chargeNow;
    // [R15] Sink through discharge device
    next_dischargeOn     = curEnable && !chargeNow;
  end

  // Driver registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chanSwitch      <= 4'h0;
      idleSupplyTie   <= 1'b0;
      idleGroundTie   <= 1'b1;
      directPath      <= 1'b0;
      dividedPath     <= 1'b0;
      tempDiodePath   <= 1'b0;
      dummyCompMux    <= 1'b0;
      capOffsetRef    <= 1'b0;
      currentSourceOn <= 1'b0;
      currentToPin    <= 1'b0;
      currentToGround <= 1'b0;
      dischargeOn     <= 1'b0;
    end else begin
      chanSwitch      <= next_chanSwitch;
      idleSupplyTie   <= next_idleSupplyTie;
      idleGroundTie   <= next_idleGroundTie;
      directPath      <= next_directPath;
      dividedPath     <= next_dividedPath;
      tempDiodePath   <= next_tempDiodePath;
      dummyCompMux    <= next_dummyCompMux;
      capOffsetRef    <= next_capOffsetRef;
      currentSourceOn <= next_currentSourceOn;
      currentToPin    <= next_currentToPin;
      currentToGround <= next_currentToGround;
      dischargeOn     <= next_dischargeOn;
    end
  end

endmodule : amc_switch_drive

`default_nettype wire

// File: amc_analog_control.sv
// Top of the analog switch and current source control with its registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R01] Each channel select bit closes its own pin switch; any combination allowed.
// [R02] No channel selected: channel bus tied to supply or ground by idle level bit.
// [R03] Any channel selected opens the supply or ground tie.
// [R04] Channel bit changes apply directly with no switch sequencing.
// [R05] Software should change only one channel bit per write.
// [R06] Channel switches stay tied to pins whatever the digital port setting.
// [R07] Direct bit alone connects comparator input bus straight to channel bus.
// [R08] Divided bit alone routes channel bus through the half divider.
// [R09] Both sample bits set select the temperature diode.
// [R10] Sample capacitor stays connected; its reference end follows offset select.
// [R11] Divided path also switches in the dummy compensation mux.
// [R12] Enabled source keeps running, steered to pin or to ground.
// [R13] Two conversion mode bits switch source and sink automatically.
// [R14] Switch control register decoded at its fixed index.
// [R15] Enable activates current function; charge select picks source or sink.
// [R16] Enable clear: source and discharge device both off.
// [R17] Enable, charge and mode bits live in the analog control register.
// [R18] Both sample bits clear: comparator input bus disconnected from every source.
module amc_analog_control (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Conversion event
  input  wire logic        compTrip,
  // Analog switch drivers
  output logic      [3:0]  chanSwitch,
  output logic             idleSupplyTie,
  output logic             idleGroundTie,
  output logic             directPath,
  output logic             dividedPath,
  output logic             tempDiodePath,
  output logic             dummyCompMux,
  output logic             capOffsetRef,
  // Current source drivers
  output logic             currentSourceOn,
  output logic             currentToPin,
  output logic             currentToGround,
  output logic             dischargeOn
);

  logic [7:0] switchCtrl, next_switchCtrl;
  logic [7:0] analogCtrl, next_analogCtrl;
  logic       capOffset, next_capOffset;
  logic       chargeNow, next_chargeNow;
  logic [7:0] analogStat;
  logic       wrStb;
  logic [7:0] wrIdx;
  logic [7:0] wrData;
  logic [1:0] convMode;
  logic       curEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  amc_apb_slave u_bus (
    .mclk       (mclk),
    .rst        (rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .switchCtrl (switchCtrl),
    .analogCtrl (analogCtrl),
    .analogStat (analogStat),
    .wrStb      (wrStb),
    .wrIdx      (wrIdx),
    .wrData     (wrData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and automatic charge direction
  always_comb begin
    next_switchCtrl = switchCtrl;
    next_analogCtrl = analogCtrl;
    next_capOffset  = capOffset;
    next_chargeNow  = chargeNow;
    curEnable       = analogCtrl[amc_pkg::CUR_EN_BIT];
    convMode        = {analogCtrl[amc_pkg::MODE2_BIT], analogCtrl[amc_pkg::MODE1_BIT]};
    // [R13] Trip driven source and sink switching
    if (curEnable && compTrip) begin
      case (convMode)
        2'b01:   next_chargeNow = 1'b0;
        2'b10:   next_chargeNow = 1'b1;
        2'b11:   next_chargeNow = !chargeNow;
        default: next_chargeNow = chargeNow;
      endcase
    end
    if (wrStb) begin
      case (wrIdx)
        // [R14] Switch control decode
        amc_pkg::SWITCH_CTRL_IDX:
          next_switchCtrl = wrData & amc_pkg::SWITCH_CTRL_MASK;
        // [R17] Analog control decode
        amc_pkg::ANALOG_CTRL_IDX: begin
          next_analogCtrl = wrData & amc_pkg::ANALOG_CTRL_MASK;
          next_chargeNow  = wrData[amc_pkg::CHARGE_BIT];
        end
        amc_pkg::ANALOG_STAT_IDX:
          next_capOffset = wrData[amc_pkg::CAP_OFFSET_BIT];
        default: next_switchCtrl = switchCtrl;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      switchCtrl <= amc_pkg::SWITCH_CTRL_RST;
      analogCtrl <= amc_pkg::ANALOG_CTRL_RST;
      capOffset  <= amc_pkg::ANALOG_STAT_RST[amc_pkg::CAP_OFFSET_BIT];
      chargeNow  <= amc_pkg::ANALOG_CTRL_RST[amc_pkg::CHARGE_BIT];
    end else begin
      switchCtrl <= next_switchCtrl;
      analogCtrl <= next_analogCtrl;
      capOffset  <= next_capOffset;
      chargeNow  <= next_chargeNow;
    end
  end

  // Status readback
  always_comb begin
    analogStat = 8'h00;
    analogStat[amc_pkg::CAP_OFFSET_BIT] = capOffset;
    analogStat[amc_pkg::CHARGE_NOW_BIT] = chargeNow;
    analogStat[amc_pkg::ANY_CHAN_BIT]   =
      amc_pkg::any_chan(switchCtrl[amc_pkg::CHAN_SEL_LSB +: amc_pkg::CHAN_SEL_W]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch drivers; no port direction input exists, so switches follow only the register
  // [R06] Pins always wired
  amc_switch_drive u_drive (
    .mclk            (mclk),
    .rst             (rst),
    .switchCtrl      (switchCtrl),
    .curEnable       (curEnable),
    .chargeNow       (chargeNow),
    .capOffset       (capOffset),
    .chanSwitch      (chanSwitch),
    .idleSupplyTie   (idleSupplyTie),
    .idleGroundTie   (idleGroundTie),
    .directPath      (directPath),
    .dividedPath     (dividedPath),
    .tempDiodePath   (tempDiodePath),
    .dummyCompMux    (dummyCompMux),
    .capOffsetRef    (capOffsetRef),
    .currentSourceOn (currentSourceOn),
    .currentToPin    (currentToPin),
    .currentToGround (currentToGround),
    .dischargeOn     (dischargeOn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_switchWrite;
    wrStb && wrIdx == amc_pkg::SWITCH_CTRL_IDX;
  endsequence

  sequence s_ctrlWrite;
    wrStb && wrIdx == amc_pkg::ANALOG_CTRL_IDX;
  endsequence

  property p_chanFollows;
    @(posedge mclk) disable iff (rst)
      s_switchWrite |=> ##1 (chanSwitch == $past(wrData[3:0], 2));
  endproperty
  a_chanFollows: assert property (p_chanFollows) else $error("Channel switches wrong"); // [R01]

  property p_idleTie;
    @(posedge mclk) disable iff (rst)
      (switchCtrl[3:0] == 4'h0) |=>
        (idleSupplyTie == $past(switchCtrl[amc_pkg::IDLE_LEVEL_BIT])) &&
        (idleGroundTie != $past(switchCtrl[amc_pkg::IDLE_LEVEL_BIT]));
  endproperty
  a_idleTie: assert property (p_idleTie) else $error("Idle tie wrong"); // [R02]

  property p_idleOpen;
    @(posedge mclk) disable iff (rst)
      (chanSwitch != 4'h0) |-> !idleSupplyTie && !idleGroundTie;
  endproperty
  a_idleOpen: assert property (p_idleOpen) else $error("Idle tie not open"); // [R03]

  property p_noSequencing;
    @(posedge mclk) disable iff (rst)
      $changed(switchCtrl[3:0]) |=> (chanSwitch == $past(switchCtrl[3:0]));
  endproperty
  a_noSequencing: assert property (p_noSequencing) else $error("Switch change delayed"); // [R04]

  property p_pathSelect;
    @(posedge mclk) disable iff (rst)
      ##1 (directPath == ($past(switchCtrl[7]) && !$past(switchCtrl[6]))) &&
          (dividedPath == ($past(switchCtrl[6]) && !$past(switchCtrl[7]))) &&
          (tempDiodePath == ($past(switchCtrl[6]) && $past(switchCtrl[7])));
  endproperty
  a_pathSelect: assert property (p_pathSelect) else $error("Input path wrong"); // [R07]

  property p_onePath;
    @(posedge mclk) disable iff (rst)
      $onehot0({directPath, dividedPath, tempDiodePath});
  endproperty
  a_onePath: assert property (p_onePath) else $error("Two input paths on"); // [R18]

  property p_dummyMux;
    @(posedge mclk) disable iff (rst)
      dummyCompMux == dividedPath;
  endproperty
  a_dummyMux: assert property (p_dummyMux) else $error("Dummy mux mismatch"); // [R11]

  property p_capRef;
    @(posedge mclk) disable iff (rst)
      (wrStb && wrIdx == amc_pkg::ANALOG_STAT_IDX) |=> ##1 (capOffsetRef == $past(wrData[0], 2));
  endproperty
  a_capRef: assert property (p_capRef) else $error("Capacitor reference wrong"); // [R10]

  property p_steer;
    @(posedge mclk) disable iff (rst)
      currentSourceOn |-> (currentToPin != currentToGround) && (dischargeOn == currentToGround);
  endproperty
  a_steer: assert property (p_steer) else $error("Current steering wrong"); // [R12]

  property p_enableOff;
    @(posedge mclk) disable iff (rst)
      (s_ctrlWrite ##0 !wrData[0]) |=> ##1 (!currentSourceOn && !dischargeOn && !currentToPin);
  endproperty
  a_enableOff: assert property (p_enableOff) else $error("Current function not off"); // [R16]

  property p_chargeSel;
    @(posedge mclk) disable iff (rst)
      (s_ctrlWrite ##0 wrData[0]) |=> ##1 (currentToPin == $past(wrData[1], 2));
  endproperty
  a_chargeSel: assert property (p_chargeSel) else $error("Charge select wrong"); // [R15]

  property p_autoSink;
    @(posedge mclk) disable iff (rst)
      (curEnable && compTrip && convMode == 2'b01 && !wrStb) |=> ##1 !currentToPin;
  endproperty
  a_autoSink: assert property (p_autoSink) else $error("Auto sink missed"); // [R13]

endmodule : amc_analog_control

`default_nettype wire

// File: amc_pin_model.sv
// Behavioural model of the external ramp circuit on the current pin
`timescale 1ns/1ps
`default_nettype none

module amc_pin_model #(
  parameter int TRIP_CYCLES = 8
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Current steering seen at the pin
  input  wire logic currentSourceOn,
  input  wire logic currentToPin,
  // Comparator event
  output logic      compTrip
);
  logic [7:0] rampCount;
  logic       lastToPin;

  ////////////////////////////////////////////////////////////////////////////
  // Ramp on the external capacitor trips the comparator after a steady run
  // pins always wired
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rampCount <= 8'h00;
      lastToPin <= 1'b0;
      compTrip  <= 1'b0;
    end else begin
      compTrip  <= 1'b0;
      lastToPin <= currentToPin;
      if (!currentSourceOn || currentToPin != lastToPin) begin
        rampCount <= 8'h00; // Steering change restarts the ramp
      end else if (rampCount == 8'(TRIP_CYCLES - 1)) begin
        compTrip  <= 1'b1;
        rampCount <= 8'h00;
      end else begin
        rampCount <= rampCount + 8'h01;
      end
    end
  end
endmodule : amc_pin_model
`default_nettype wire

// File: amc_analog_control_tb.sv
// Self-checking bench for the analog switch and current source control
`timescale 1ns/1ps
`default_nettype none

module amc_analog_control_tb;
  localparam logic [7:0] A_SW = amc_pkg::SWITCH_CTRL_IDX << 2;
  localparam logic [7:0] A_AC = amc_pkg::ANALOG_CTRL_IDX << 2;
  localparam logic [7:0] A_ST = amc_pkg::ANALOG_STAT_IDX << 2;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, compTrip;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  chanSwitch;
  logic        idleSupplyTie, idleGroundTie, directPath, dividedPath, tempDiodePath;
  logic        dummyCompMux, capOffsetRef, currentSourceOn, currentToPin;
  logic        currentToGround, dischargeOn;
  logic [14:0] drvSeen;
  logic [33:0] expQ[$];
  logic [7:0]  swVal;
  logic        curEn, chgDir, offSel;
  logic [3:0]  g;
  logic [1:0]  m;
  logic [31:0] r;
  int          failures, num_checks, seed, n, i;

  amc_analog_control dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compTrip(compTrip), .chanSwitch(chanSwitch),
    .idleSupplyTie(idleSupplyTie), .idleGroundTie(idleGroundTie), .directPath(directPath),
    .dividedPath(dividedPath), .tempDiodePath(tempDiodePath), .dummyCompMux(dummyCompMux),
    .capOffsetRef(capOffsetRef), .currentSourceOn(currentSourceOn),
    .currentToPin(currentToPin), .currentToGround(currentToGround), .dischargeOn(dischargeOn));

  amc_pin_model #(.TRIP_CYCLES(8)) pins (.mclk(mclk), .rst(rst),
    .currentSourceOn(currentSourceOn), .currentToPin(currentToPin), .compTrip(compTrip));

  // Driver levels gathered for one comparison
  assign drvSeen = {chanSwitch, idleSupplyTie, idleGroundTie, directPath, dividedPath,
                    tempDiodePath, dummyCompMux, capOffsetRef, currentSourceOn,
                    currentToPin, currentToGround, dischargeOn};

  ////////////////////////////////////////////////////////////////////////////
  // Expected drivers from the bench's copy of the control state
  function automatic logic [14:0] expect_drv();
    logic any;
    any = |swVal[3:0];
    return {swVal[3:0], !any & swVal[5], !any & !swVal[5], swVal[7] & !swVal[6],
            swVal[6] & !swVal[7], swVal[7] & swVal[6], swVal[6] & !swVal[7], offSel,
            curEn, curEn & chgDir, curEn & !chgDir, curEn & !chgDir};
  endfunction : expect_drv

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_drv(input string name, input logic [14:0] exp);
    num_checks++;
    if (drvSeen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, drvSeen);
    end
  endtask : chk_drv

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the answer is noted for the monitor
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     input logic [31:0] expd, input logic experr);
    int w;
    expQ.push_back({wr, experr, expd});
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (w >= 20) failures++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write with random upper bits, then compare drivers one edge later
  task automatic wr(input logic [7:0] addr, input logic [7:0] val);
    logic [31:0] d;
    d = $random(seed);
    d[7:0] = val;
    apb(1'b1, addr, d, 32'h0, 1'b0);
    @(posedge mclk);
    #1 chk_drv("drivers", expect_drv());
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  // Monitor takes the oldest note at each completed transfer
  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("MISMATCH apb note expected queued seen none");
      end else begin
        chk_word("pslverr", {31'h0, expQ[0][32]}, {31'h0, pslverr});
        if (!expQ[0][33]) chk_word("prdata", expQ[0][31:0], prdata);
        void'(expQ.pop_front());
      end
    end
  end

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog
  initial begin
    #500000;
    failures++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 79;
    failures = 0;
    num_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {swVal, curEn, chgDir, offSel} = '0;
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1 chk_drv("reset drivers", expect_drv());
    apb(1'b0, A_SW, 32'h0, 32'h0, 1'b0);
    apb(1'b0, A_AC, 32'h0, 32'h0, 1'b0);
    apb(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
    $display("test reset done");
    // Channels walk a Gray sequence, at most one bit per write
    for (i = 1; i <= 16; i++) begin
      g = 4'(i ^ (i >> 1));
      r = $random(seed);
      swVal = {2'b00, r[0], 1'b0, g};
      wr(A_SW, swVal);
      apb(1'b0, A_SW, 32'h0, {24'h0, swVal & 8'hef}, 1'b0);
    end
    swVal = 8'h20;
    wr(A_SW, swVal);
    swVal = 8'h2f;
    wr(A_SW, swVal);
    swVal = 8'h20;
    wr(A_SW, swVal);
    $display("test channels done");
    for (i = 0; i < 4; i++) begin
      swVal = {2'(i), 6'h01};
      wr(A_SW, swVal);
    end
    offSel = 1'b1;
    wr(A_ST, 8'h01);
    offSel = 1'b0;
    wr(A_ST, 8'h00);
    $display("test paths done");
    for (i = 0; i < 4; i++) begin
      curEn = i[1];
      chgDir = i[0];
      wr(A_AC, {6'h00, chgDir, curEn});
      apb(1'b0, A_AC, 32'h0, {30'h0, chgDir, curEn}, 1'b0);
    end
    $display("test current done");
    for (i = 1; i <= 4; i++) begin
      m = 2'(i);
      curEn = 1'b1;
      chgDir = (m != 2'b10);
      wr(A_AC, {4'h0, m, chgDir, 1'b1});
      repeat ((m == 2'b11) ? 2 : 1) begin
        n = 0;
        while (currentToPin === chgDir && n < 40) begin
          @(posedge mclk);
          n++;
        end
        if (m != 2'b00) chgDir = !chgDir;
        chk_drv("mode drivers", expect_drv());
      end
    end
    $display("test modes done");
    apb(1'b1, 8'h40, 32'h0000_00ff, 32'h0, 1'b1);
    apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h0d, 32'h0, 32'h0, 1'b1);
    apb(1'b0, A_SW, 32'h0, {24'h0, swVal & 8'hef}, 1'b0);
    $display("test refusals done");
    repeat (2) @(posedge mclk);
    end_of_test();
  end
endmodule : amc_analog_control_tb
`default_nettype wire
